// [verilog/epso_top.sv]
// eye-pattern serial output: shifts X then Y bytes out on the eye clock
`timescale 1ns/10ps
`include "epso_map.svh"
module epso_top #(
  parameter bit LSB_FIRST = `EPSO_LSB_FIRST_DEF
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic EYE_SHIFT_CLOCK_IN,
  input wire epso_pkg::epso_sample_t SAMPLE_IN,
  input wire logic SAMPLE_VALID_IN,
  output logic SAMPLE_READY_OUT,
  output logic EYE_SERIAL_DATA_OUT,
  output logic EYE_FRAME_STROBE_OUT
);
  ////////////////////////////////////////////////////////////////////////
  logic eye_rise;
  epso_pkg::epso_state_t state_r;
  epso_pkg::epso_state_t state_nxt;
  logic [`EPSO_WORD_BITS-1:0] word_r;
  logic [`EPSO_WORD_BITS-1:0] word_nxt;
  logic [`EPSO_CNT_W-1:0] cnt_r;
  logic [`EPSO_CNT_W-1:0] cnt_nxt;
  logic [`EPSO_CNT_W-1:0] gap_r;
  logic [`EPSO_CNT_W-1:0] gap_nxt;
  logic have_r;
  logic have_nxt;
  epso_pkg::epso_sample_t hold_r;
  logic ready_nxt;
  logic data_nxt;
  logic stb_nxt;
  logic [7:0] x_ord;
  logic [7:0] y_ord;
  logic [`EPSO_WORD_BITS-1:0] load_word;
  logic take;
  logic last_bit;
  logic gap_done;
  logic [4:0] low_rises_r;
  logic [4:0] low_rises_nxt;

  // pin clock is foreign: synchronise before edge detect
  epso_sync u_sync (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .async_in(EYE_SHIFT_CLOCK_IN),
    .rise_out(eye_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // bit order per byte; word MSB always leaves first
  genvar gi;
  generate
    for (gi = 0; gi < `EPSO_COORD_BITS; gi++) begin : g_ord
      assign x_ord[gi] = LSB_FIRST ? hold_r.x_coord[7-gi]
                                   : hold_r.x_coord[gi];
      assign y_ord[gi] = LSB_FIRST ? hold_r.y_coord[7-gi]
                                   : hold_r.y_coord[gi];
    end
  endgenerate
  assign load_word = {x_ord, y_ord};
  assign take = SAMPLE_VALID_IN & SAMPLE_READY_OUT;
  assign last_bit = (cnt_r == 4'hF);
  assign gap_done = (gap_r >= `EPSO_IDLE_EYE_CLKS);

  ////////////////////////////////////////////////////////////////////////
  // sequencing: data and strobe pin changes wait for an eye clock rise; ready follows clk
  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    cnt_nxt = cnt_r;
    gap_nxt = gap_r;
    have_nxt = have_r | take;
    ready_nxt = ~(have_r | take);
    data_nxt = EYE_SERIAL_DATA_OUT;
    stb_nxt = EYE_FRAME_STROBE_OUT;
    if (eye_rise) begin
      unique case (state_r)
        epso_pkg::EPSO_IDLE, epso_pkg::EPSO_GAP: begin
          stb_nxt = 1'b1;
          if (gap_r != 4'hF) gap_nxt = gap_r + 4'h1;
          if (have_r && gap_done) begin
            state_nxt = epso_pkg::EPSO_SHIFT;
            word_nxt = {load_word[`EPSO_WORD_BITS-2:0], 1'b0};
            data_nxt = load_word[`EPSO_WORD_BITS-1];
            stb_nxt = 1'b0;
            cnt_nxt = 4'h0;
            have_nxt = take;
            ready_nxt = ~take;
          end
        end
        epso_pkg::EPSO_SHIFT: begin
          if (last_bit) begin
            state_nxt = epso_pkg::EPSO_GAP;
            stb_nxt = 1'b1;
            gap_nxt = 4'h0;
          end else begin
            data_nxt = word_r[`EPSO_WORD_BITS-1];
            word_nxt = {word_r[`EPSO_WORD_BITS-2:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        // unused fourth code: fall back to idle rather than lock up
        default: state_nxt = epso_pkg::EPSO_IDLE;
      endcase
    end
  end

  // sample holding register, loaded on handshake
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) hold_r <= '0;
    else if (take) hold_r <= SAMPLE_IN;
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= epso_pkg::EPSO_IDLE;
      word_r <= '0;
      cnt_r <= '0;
      gap_r <= '0;
      have_r <= 1'b0;
      SAMPLE_READY_OUT <= 1'b0;
      EYE_SERIAL_DATA_OUT <= 1'b0;
      EYE_FRAME_STROBE_OUT <= 1'b1;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      have_r <= have_nxt;
      SAMPLE_READY_OUT <= ready_nxt;
      EYE_SERIAL_DATA_OUT <= data_nxt;
      EYE_FRAME_STROBE_OUT <= stb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_stb_on_rise;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    $changed(EYE_FRAME_STROBE_OUT) |-> $past(eye_rise);
  endproperty
  a_stb_on_rise: assert property (p_stb_on_rise)
    else $error("strobe moved without eye clock rise");

  property p_data_on_rise;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    $changed(EYE_SERIAL_DATA_OUT) |-> $past(eye_rise);
  endproperty
  a_data_on_rise: assert property (p_data_on_rise)
    else $error("data moved without eye clock rise");

  // eye rises seen with the strobe low, closing rise included; a counter
  // instead of a long repetition keeps the property cheap to unroll
  assign low_rises_nxt = EYE_FRAME_STROBE_OUT ? 5'h00 :
                         (eye_rise && low_rises_r != 5'h1F) ?
                         low_rises_r + 5'h01 : low_rises_r;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) low_rises_r <= 5'h00;
    else low_rises_r <= low_rises_nxt;
  end

  sequence s_word_end;
    $rose(EYE_FRAME_STROBE_OUT);
  endsequence

  property p_low_len;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    s_word_end |-> (low_rises_r == `EPSO_LOW_RISES);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("strobe low for wrong number of eye clocks");

  property p_word_len;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    $rose(EYE_FRAME_STROBE_OUT) |-> $past(cnt_r) == 4'hF;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word not 16 bits");

  property p_gap;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    $fell(EYE_FRAME_STROBE_OUT) |-> $past(gap_r) >= 4'h1;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no high gap before word");

  property p_first_bit;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    $fell(EYE_FRAME_STROBE_OUT) |-> EYE_SERIAL_DATA_OUT ==
      (LSB_FIRST ? $past(hold_r.x_coord[0]) : $past(hold_r.x_coord[7]));
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit not X leading bit");

  property p_ready;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    SAMPLE_READY_OUT |-> !have_r;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready while holding sample");

  property p_shift_low;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == epso_pkg::EPSO_SHIFT) |-> !EYE_FRAME_STROBE_OUT;
  endproperty
  a_shift_low: assert property (p_shift_low)
    else $error("strobe high during word");
endmodule : epso_top

// [common/epso_map.svh]
// widths, counts and default bit order for the eye-pattern serial output
`ifndef EPSO_MAP_SVH
`define EPSO_MAP_SVH
`define EPSO_COORD_BITS 8
`define EPSO_WORD_BITS 16
`define EPSO_CNT_W 4
`define EPSO_IDLE_EYE_CLKS 4'h1
`define EPSO_LOW_RISES 5'h10
`define EPSO_LSB_FIRST_DEF 1'b1
`endif

// [common/epso_pkg.sv]
// types for the eye-pattern serial output
package epso_pkg;
  typedef struct packed {
    logic [7:0] x_coord;
    logic [7:0] y_coord;
  } epso_sample_t;
  typedef enum logic [1:0] {
    EPSO_IDLE,
    EPSO_GAP,
    EPSO_SHIFT
  } epso_state_t;
endpackage : epso_pkg

// [verilog/epso_sync.sv]
// two-flop synchroniser with rising-edge detect on the second stage output
`timescale 1ns/10ps
module epso_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic rise_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // only the second stage and later are looked at
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign rise_out = sync_r & ~prev_r;
endmodule : epso_sync

// [verif/epso_rx_model.sv]
// partner model: external shift register feeding the display d/a
`timescale 1ns/10ps
module epso_rx_model (
  input wire logic eye_clk_in,
  input wire logic data_in,
  input wire logic strobe_in,
  output logic [15:0] word_out,
  output logic [4:0] nbits_out,
  output logic gap_short_out,
  output int words_out
);
  logic [15:0] sr_r;
  logic [4:0] cnt_r;
  logic gap_r;
  initial begin
    word_out = 16'h0000;
    nbits_out = 5'h00;
    gap_short_out = 1'b0;
    words_out = 0;
    sr_r = 16'h0000;
    cnt_r = 5'h00;
    gap_r = 1'b1;
  end
  ////////////////////////////////////////
  // capture half a period after launch, when the bit is settled
  always @(negedge eye_clk_in) begin
    if (strobe_in === 1'b0) begin
      // a word starting with no high strobe sample is a lost boundary
      if (cnt_r == 5'h00 && !gap_r) gap_short_out <= 1'b1;
      sr_r <= {data_in, sr_r[15:1]};
      cnt_r <= cnt_r + 5'h01;
      gap_r <= 1'b0;
    end else begin
      if (cnt_r != 5'h00) begin
        word_out <= sr_r;
        nbits_out <= cnt_r;
        words_out <= words_out + 1;
      end
      cnt_r <= 5'h00;
      gap_r <= 1'b1;
    end
  end
endmodule : epso_rx_model

// [verif/epso_top_test.sv]
// self-checking bench for the eye-pattern serial output
`timescale 1ns/10ps
module epso_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic eye_clk = 1'b0;
  logic valid = 1'b0;
  epso_pkg::epso_sample_t sample = 16'h0000;
  logic ready, sdata, strobe, gap_short;
  logic [15:0] word;
  logic [4:0] nbits;
  int words, failures = 0, n_checks = 0, cycles = 0;
  logic ready_m, sdata_m, strobe_m, gap_short_m;
  logic [15:0] word_m;
  logic [4:0] nbits_m;
  int words_m;
  always #50 clk = ~clk;
  // eye clock free-running, phase unrelated to clk
  initial begin
    #137;
    forever #400 eye_clk = ~eye_clk;
  end
  epso_top #(.LSB_FIRST(1'b1)) epso_top_inst (.CLK_IN(clk),
    .RESET_N_IN(rst_n), .EYE_SHIFT_CLOCK_IN(eye_clk), .SAMPLE_IN(sample),
    .SAMPLE_VALID_IN(valid), .SAMPLE_READY_OUT(ready),
    .EYE_SERIAL_DATA_OUT(sdata), .EYE_FRAME_STROBE_OUT(strobe));
  epso_rx_model epso_rx_model_inst (.eye_clk_in(eye_clk), .data_in(sdata),
    .strobe_in(strobe), .word_out(word), .nbits_out(nbits),
    .gap_short_out(gap_short), .words_out(words));
  // second build with msb-first bytes, fed the very same samples
  epso_top #(.LSB_FIRST(1'b0)) epso_top_msb_inst (.CLK_IN(clk),
    .RESET_N_IN(rst_n), .EYE_SHIFT_CLOCK_IN(eye_clk), .SAMPLE_IN(sample),
    .SAMPLE_VALID_IN(valid), .SAMPLE_READY_OUT(ready_m),
    .EYE_SERIAL_DATA_OUT(sdata_m), .EYE_FRAME_STROBE_OUT(strobe_m));
  epso_rx_model epso_rx_model_msb_inst (.eye_clk_in(eye_clk),
    .data_in(sdata_m), .strobe_in(strobe_m), .word_out(word_m),
    .nbits_out(nbits_m), .gap_short_out(gap_short_m), .words_out(words_m));
  // bit reversal of one byte, for the msb-first expectation
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = b[7 - i];
    return r;
  endfunction : rev8
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // hang guard: a word takes about 140 clk cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("MISMATCH %0t timeout", $time);
      conclude();
    end
  end
  // data and strobe may only move in the high half of the eye clock
  always @(strobe or sdata or strobe_m or sdata_m) begin
    if (rst_n && !eye_clk) begin
      failures++;
      $display("MISMATCH %0t output moved with eye clock low", $time);
    end
  end
  task automatic send(input epso_pkg::epso_sample_t s);
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    sample = s;
    valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0;
    sample = ~s; // a released input does not keep its value
  endtask : send
  // expected word in arrival order: x bits first, each lsb first (msb first for the msb build)
  task automatic expect_word(input int idx, input epso_pkg::epso_sample_t s);
    while (words < idx || words_m < idx) @(negedge clk);
    n_checks++;
    if (word !== {s.y_coord, s.x_coord} || nbits !== 5'h10 || gap_short) begin
      failures++;
      $display("MISMATCH %0t word %h bits %0d", $time, word, nbits);
    end
    n_checks++;
    if (word_m !== {rev8(s.y_coord), rev8(s.x_coord)} ||
        nbits_m !== 5'h10 || gap_short_m) begin
      failures++;
      $display("MISMATCH %0t msb word %h bits %0d", $time, word_m, nbits_m);
    end
  endtask : expect_word
  task automatic t_idle();
    n_checks++;
    if (strobe !== 1'b1 || ready !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t idle strobe or ready wrong", $time);
    end
    n_checks++;
    if (strobe_m !== 1'b1 || ready_m !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t msb build idle strobe or ready wrong", $time);
    end
  endtask : t_idle
  task automatic t_single();
    send(16'h0180);
    expect_word(1, 16'h0180);
  endtask : t_single
  task automatic t_back2back();
    send(16'hA53C);
    send(16'hFF00);
    expect_word(2, 16'hA53C);
    expect_word(3, 16'hFF00);
  endtask : t_back2back
  ////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_idle();
    t_single();
    t_back2back();
    repeat (20) @(negedge clk);
    t_idle();
    conclude();
  end
endmodule : epso_top_test
